// ---- include/fcw_params.svh ----
// Constants for the flash configuration and status write block.
`ifndef FCW_PARAMS_SVH
`define FCW_PARAMS_SVH
// -----------------------------------------------------------------------------
// Command opcodes
// -----------------------------------------------------------------------------
`define FCW_OP_WRITE_ENABLE_CMD 8'h06
`define FCW_OP_WRDI 8'h04
`define FCW_OP_WRITE_STATUS_CMD 8'h01
`define FCW_OP_RDSR 8'h05
`define FCW_OP_RDCR 8'h15
`define FCW_OP_EN_WIDE 8'hb7
`define FCW_OP_EX_WIDE 8'he9
// -----------------------------------------------------------------------------
// Frame bit counts (opcode included) and saturation
// -----------------------------------------------------------------------------
`define FCW_CNT_OP 5'h08
`define FCW_CNT_ONE 5'h10
`define FCW_CNT_TWO 5'h18
`define FCW_CNT_MAX 5'h1f
// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define FCW_ST_LOCK 7
`define FCW_ST_QE 6
`define FCW_ST_LVL_HI 5
`define FCW_ST_LVL_LO 2
`define FCW_CR_DC_HI 7
`define FCW_CR_DC_LO 6
`define FCW_CR_BOT 3
`define FCW_CR_ODS_HI 2
`define FCW_CR_ODS_LO 0
// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define FCW_ODS_RST 3'h7
`define FCW_DC_RST 2'h0
`define FCW_LVL_RST 4'h0
`define FCW_OHM_RST 7'h1e
`define FCW_DUMMY_FAST_RST 4'h8
`define FCW_DUMMY_QIO_RST 4'h6
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define FCW_CLK_NS 50
`define FCW_TW_NS 40000
`endif

// ---- include/fcw_pkg.sv ----
// Types shared by the flash configuration and status write block.
package fcw_pkg;
  typedef enum logic [0:0] {
    FCW_WR_IDLE = 1'b0,
    FCW_WR_BUSY = 1'b1
  } fcw_wr_state_type;
endpackage : fcw_pkg

// ---- core/fcw_sync.sv ----
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module fcw_sync import fcw_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : fcw_sync

// ---- core/fcw_protect_chk.sv ----
// Decides whether an address falls inside the protected area.
`timescale 1ns/1ps
module fcw_protect_chk import fcw_pkg::*; #(
  parameter int BLK_W = 9
) (
  // Protection setting
  input wire logic [3:0] protect_level_i,
  input wire logic protect_from_bottom_i,
  // Address block
  input wire logic [BLK_W-1:0] blk_i,
  output logic hit_o
);
  localparam logic [15:0] NUM_BLK = 16'(2 ** BLK_W);
  logic [15:0] shifted;
  logic [15:0] covered;
  logic [15:0] blk_ext;

  // Level n covers 2^(n-1) blocks, clipped to the whole array.
  assign shifted = 16'h0001 << (protect_level_i - 4'h1);
  assign covered = (protect_level_i == 4'h0) ? 16'h0000 : ((shifted > NUM_BLK) ? NUM_BLK : shifted);
  assign blk_ext = 16'(blk_i);
  assign hit_o = protect_from_bottom_i ? (blk_ext < covered) : (blk_ext >= (NUM_BLK - covered));
endmodule : fcw_protect_chk

// ---- core/fcw_top.sv ----
// Configuration register and status register write handling of a serial flash.
// -----------------------------------------------------------------------------
// What this block does
// - Drive-strength select resets to code 111, the 30 ohm setting.
// - Drive-strength codes decode to 90,60,45,20,15,30 ohm; 000 and 100 reserved.
// - Drive-strength select changes only through the write-status command.
// - Protect-from-bottom is one-time bit, reset 0 for top, written by write-status.
// - Enter-wide-address sets the wide flag, exit clears it, reset clears it.
// - Config byte: dummy count 7:6, wide 5, reserved 4, bottom 3, drive 2:0.
// - Fast and quad-output reads use 8, 6, 8, 10 dummy clocks per code.
// - Quad I/O fast read uses 6, 4, 8, 10 dummy clocks per code.
// - Write-status updates registers only when the write latch was set beforehand.
// - Write-status data never alters the write-latch and write-busy status bits.
// - Select must rise after exactly 8 or 16 data bits, else command rejected.
// - Self-timed write starts as soon as select rises after an accepted command.
// - Busy reads 1 during the write, then clears along with the write latch.
// - With lock at 0, write-enable sets the latch whatever the pin level.
// - With lock at 1 and pin high, write-enable and status changes still work.
// - With lock at 1, pin low, quad-enable 0 and quad-command mode off, every status write is rejected.
// - Hard protect holds whenever lock is 1, pin low, quad-enable 0 and quad-command mode off, in either order.
// - Hard protect ends when the pin is driven high or quad-command mode is set.
// - Quad-enable or quad-command mode disables hard protect.
// - Program and erase to the protected area are refused in both modes.
// - Lock bit and protect-level bits reset to 0, array unprotected.
// -----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "fcw_params.svh"
module fcw_top import fcw_pkg::*; #(
  parameter int BLK_W = 9,
  parameter int ADDR_W = 25,
  parameter int TW_NS = `FCW_TW_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // Write-protect pin and mode
  input wire logic write_protect_pin_n_i,
  input wire logic quad_command_mode_i,
  // Program and erase check
  input wire logic pe_req_i,
  input wire logic [ADDR_W-1:0] pe_addr_i,
  output logic pe_refused_o,
  // Register and state view
  output logic [7:0] status_o,
  output logic [7:0] config_reg_o,
  output logic hard_protect_mode_o,
  output logic [6:0] drive_ohms_o,
  output logic [3:0] dummy_fast_o,
  output logic [3:0] dummy_quad_io_o
);
  localparam int TW_CYCLES = (TW_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS;
  localparam logic [15:0] TW_LAST = 16'(TW_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic cs_n_s, sclk_s, si_s, wp_n_s;
  logic sclk_prev_q, cs_prev_q;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;

  fcw_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({cs_n_i, sclk_i, si_i, write_protect_pin_n_i}),
    .sync_o(pins_s)
  );

  assign {cs_n_s, sclk_s, si_s, wp_n_s} = pins_s;
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_prev_q;
  assign cs_fall = ~cs_n_s & cs_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------------------
  logic [4:0] bit_cnt_q;
  logic [7:0] opcode_q;
  logic [15:0] data_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || cs_fall) begin
      bit_cnt_q <= 5'h00;
      opcode_q <= 8'h00;
      data_q <= 16'h0000;
    end else if (sclk_rise) begin
      if (bit_cnt_q != `FCW_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (bit_cnt_q < `FCW_CNT_OP) begin
        opcode_q <= {opcode_q[6:0], si_s};
      end else begin
        data_q <= {data_q[14:0], si_s};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  fcw_wr_state_type wr_state_q;
  logic [15:0] wr_cnt_q;
  logic write_busy_q, write_latch_q, status_lock_q, quad_io_on_q;
  logic [3:0] protect_level_q;
  logic [2:0] drive_strength_sel_q;
  logic protect_from_bottom_q, wide_address_flag_q;
  logic [1:0] dummy_count_sel_q;
  logic [7:0] pend_status_q, pend_config_q;
  logic pend_cfg_q;

  logic hard_protect;
  logic one_byte, two_byte, frame_write_status_cmd, write_status_cmd_ok, wr_done;
  logic cmd_done, write_enable_cmd_ok, wrdi_ok, en_wide_ok, ex_wide_ok;
  logic [7:0] new_status;

  // Hard protect follows lock and pin level alike, whichever came first.
  assign hard_protect = status_lock_q & ~wp_n_s & ~quad_io_on_q & ~quad_command_mode_i;
  assign one_byte = (bit_cnt_q == `FCW_CNT_ONE);
  assign two_byte = (bit_cnt_q == `FCW_CNT_TWO);
  assign frame_write_status_cmd = (opcode_q == `FCW_OP_WRITE_STATUS_CMD) & (one_byte | two_byte);
  assign write_status_cmd_ok = cs_rise & frame_write_status_cmd & write_latch_q & ~write_busy_q & ~hard_protect;
  assign new_status = two_byte ? data_q[15:8] : data_q[7:0];
  assign cmd_done = cs_rise & (bit_cnt_q == `FCW_CNT_OP) & ~write_busy_q;
  assign write_enable_cmd_ok = cmd_done & (opcode_q == `FCW_OP_WRITE_ENABLE_CMD);
  assign wrdi_ok = cmd_done & (opcode_q == `FCW_OP_WRDI);
  assign en_wide_ok = cmd_done & (opcode_q == `FCW_OP_EN_WIDE);
  assign ex_wide_ok = cmd_done & (opcode_q == `FCW_OP_EX_WIDE);
  assign wr_done = (wr_state_q == FCW_WR_BUSY) & (wr_cnt_q == 16'h0000);

  // Self-timed write sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_state_q <= FCW_WR_IDLE;
      wr_cnt_q <= 16'h0000;
      write_busy_q <= 1'b0;
      pend_status_q <= 8'h00;
      pend_config_q <= 8'h00;
      pend_cfg_q <= 1'b0;
    end else begin
      case (wr_state_q)
        FCW_WR_IDLE: begin
          if (write_status_cmd_ok) begin
            wr_state_q <= FCW_WR_BUSY;
            wr_cnt_q <= TW_LAST;
            write_busy_q <= 1'b1;
            pend_status_q <= new_status;
            pend_config_q <= data_q[7:0];
            pend_cfg_q <= two_byte;
          end
        end
        FCW_WR_BUSY: begin
          if (wr_done) begin
            wr_state_q <= FCW_WR_IDLE;
            write_busy_q <= 1'b0;
          end else begin
            wr_cnt_q <= wr_cnt_q - 16'h0001;
          end
        end
        default: begin
          wr_state_q <= FCW_WR_IDLE;
          write_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Write latch.
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_done || wrdi_ok) begin
      write_latch_q <= 1'b0;
    end else if (write_enable_cmd_ok) begin
      write_latch_q <= 1'b1;
    end
  end

  // Status fields, written only at the end of the timed write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_lock_q <= 1'b0;
      quad_io_on_q <= 1'b0;
      protect_level_q <= `FCW_LVL_RST;
    end else if (wr_done) begin
      status_lock_q <= pend_status_q[`FCW_ST_LOCK];
      quad_io_on_q <= pend_status_q[`FCW_ST_QE];
      protect_level_q <= pend_status_q[`FCW_ST_LVL_HI:`FCW_ST_LVL_LO];
    end
  end

  // Configuration fields.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_strength_sel_q <= `FCW_ODS_RST;
      protect_from_bottom_q <= 1'b0;
      dummy_count_sel_q <= `FCW_DC_RST;
    end else if (wr_done && pend_cfg_q) begin
      drive_strength_sel_q <= pend_config_q[`FCW_CR_ODS_HI:`FCW_CR_ODS_LO];
      protect_from_bottom_q <= protect_from_bottom_q | pend_config_q[`FCW_CR_BOT];
      dummy_count_sel_q <= pend_config_q[`FCW_CR_DC_HI:`FCW_CR_DC_LO];
    end
  end

  // Wide address flag.
  always_ff @(posedge clk_i) begin
    if (rst_i || ex_wide_ok) begin
      wide_address_flag_q <= 1'b0;
    end else if (en_wide_ok) begin
      wide_address_flag_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Decoded views
  // ---------------------------------------------------------------------------
  logic [7:0] status_val, config_val;
  logic [6:0] ohms;
  logic [3:0] dummy_fast, dummy_qio;

  assign status_val = {status_lock_q, quad_io_on_q, protect_level_q, write_latch_q, write_busy_q};
  assign config_val = {dummy_count_sel_q, wide_address_flag_q, 1'b0, protect_from_bottom_q,
                       drive_strength_sel_q};
  assign ohms = (drive_strength_sel_q == 3'h1) ? 7'h5a :
                (drive_strength_sel_q == 3'h2) ? 7'h3c :
                (drive_strength_sel_q == 3'h3) ? 7'h2d :
                (drive_strength_sel_q == 3'h5) ? 7'h14 :
                (drive_strength_sel_q == 3'h6) ? 7'h0f :
                (drive_strength_sel_q == 3'h7) ? 7'h1e : 7'h00;
  assign dummy_fast = (dummy_count_sel_q == 2'h1) ? 4'h6 :
                      (dummy_count_sel_q == 2'h3) ? 4'ha : 4'h8;
  assign dummy_qio = (dummy_count_sel_q == 2'h0) ? 4'h6 :
                     (dummy_count_sel_q == 2'h1) ? 4'h4 :
                     (dummy_count_sel_q == 2'h2) ? 4'h8 : 4'ha;

  // ---------------------------------------------------------------------------
  // Protected area check and register read-out
  // ---------------------------------------------------------------------------
  logic area_hit;
  logic reading;
  logic [7:0] rd_byte;
  logic [2:0] rd_idx_q;
  logic so_q, so_oe_n_q, pe_refused_q, hpm_q;
  logic [6:0] ohms_q;
  logic [3:0] dummy_fast_q, dummy_qio_q;

  fcw_protect_chk #(.BLK_W(BLK_W)) u_chk (
    .protect_level_i(protect_level_q),
    .protect_from_bottom_i(protect_from_bottom_q),
    .blk_i(pe_addr_i[ADDR_W-1 -: BLK_W]),
    .hit_o(area_hit)
  );

  assign reading = (bit_cnt_q >= `FCW_CNT_OP) &
                   ((opcode_q == `FCW_OP_RDSR) | (opcode_q == `FCW_OP_RDCR));
  assign rd_byte = (opcode_q == `FCW_OP_RDSR) ? status_val : config_val;

  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n_s) begin
      rd_idx_q <= 3'h7;
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (sclk_fall && reading) begin
      rd_idx_q <= rd_idx_q - 3'h1;
      so_q <= rd_byte[rd_idx_q];
      so_oe_n_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_refused_q <= 1'b0;
      hpm_q <= 1'b0;
      ohms_q <= `FCW_OHM_RST;
      dummy_fast_q <= `FCW_DUMMY_FAST_RST;
      dummy_qio_q <= `FCW_DUMMY_QIO_RST;
    end else begin
      pe_refused_q <= pe_req_i & area_hit;
      hpm_q <= hard_protect;
      ohms_q <= ohms;
      dummy_fast_q <= dummy_fast;
      dummy_qio_q <= dummy_qio;
    end
  end

  assign so_o = so_q;
  assign so_oe_n_o = so_oe_n_q;
  assign pe_refused_o = pe_refused_q;
  assign status_o = status_val;
  assign config_reg_o = config_val;
  assign hard_protect_mode_o = hpm_q;
  assign drive_ohms_o = ohms_q;
  assign dummy_fast_o = dummy_fast_q;
  assign dummy_quad_io_o = dummy_qio_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_busy_starts: assert property (write_status_cmd_ok |=> write_busy_q && !write_latch_q == 1'b0)
    else $error("busy did not start after accepted write");
  a_busy_ends_latch: assert property ($fell(write_busy_q) |-> !write_latch_q)
    else $error("write latch still set after write cycle");
  a_busy_length: assert property (write_status_cmd_ok |=> (write_busy_q && wr_cnt_q == TW_LAST))
    else $error("timed write count wrong at start");
  a_reject_hpm: assert property ((cs_rise && hard_protect) |=> !write_busy_q || $past(write_busy_q))
    else $error("write started in hard protect");
  a_reject_frame: assert property ((cs_rise && (opcode_q == `FCW_OP_WRITE_STATUS_CMD) && !frame_write_status_cmd
                                    && !write_busy_q) |=> !write_busy_q)
    else $error("badly sized write was accepted");
  a_bottom_sticky: assert property ($past(protect_from_bottom_q) |-> protect_from_bottom_q)
    else $error("bottom bit returned to zero");
  a_ods_only_write_status_cmd: assert property ($changed(drive_strength_sel_q) |-> $past(wr_done && pend_cfg_q))
    else $error("drive strength changed outside write");
  a_wide_enter: assert property (en_wide_ok |=> wide_address_flag_q)
    else $error("wide flag not set");
  a_one_byte_cfg: assert property ((wr_done && !pend_cfg_q) |=> $stable(config_val))
    else $error("config changed on one byte write");
  a_hpm_flag: assert property ((status_lock_q && !wp_n_s && !quad_io_on_q && !quad_command_mode_i)
                               |=> hard_protect_mode_o)
    else $error("hard protect not flagged");
endmodule : fcw_top

// ---- tb/fcw_host_model.sv ----
// SPI host model that frames commands for the configuration block.
`timescale 1ns/1ps
module fcw_host_model import fcw_pkg::*; #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic clk_i,
  // Link pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  // ---------------------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Frame transfer
  // ---------------------------------------------------------------------------
  // Sends n bits from the top of d, mode 0, MSB first, then raises select.
  // The serial clock stands low between frames.
  task automatic xfer(input logic [23:0] d, input int n, output logic [15:0] r);
    int i;
    r = 16'h0000;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (i = 0; i < n; i++) begin
      si_o = d[23-i];
      repeat (HALF) @(negedge clk_i);
      r = {r[14:0], so_oe_n_i ? 1'b0 : so_i};
      sclk_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (2 * HALF) @(negedge clk_i);
  endtask : xfer
endmodule : fcw_host_model

// ---- tb/tb_top.sv ----
// Testbench for the flash configuration and status write block.
`timescale 1ns/1ps
`include "fcw_params.svh"
module tb_top import fcw_pkg::*; ;
  localparam int TW = 500;
  localparam int TW_CYC = TW / `FCW_CLK_NS;
  localparam logic [6:0] OHM [8] = '{7'h00, 7'h5a, 7'h3c, 7'h2d, 7'h00, 7'h14, 7'h0f, 7'h1e};
  localparam logic [3:0] DF [4] = '{4'h8, 4'h6, 4'h8, 4'ha};
  localparam logic [3:0] DQ [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
  logic clk_i, rst_i, cs_n, sclk, si, so, so_oe_n, wp_n, qmode, pe_req, pe_refused, hard_protect_mode;
  logic [24:0] pe_addr;
  logic [7:0] st, cr;
  logic [6:0] ohms;
  logic [3:0] dfast, dqio;
  int miscompares, checked;
  int busy_run = 0;
  int busy_len = 0;

  // ---------------------------------------------------------------------------
  // Design and host
  // ---------------------------------------------------------------------------
  fcw_top #(.TW_NS(TW)) u_fcw_top (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .write_protect_pin_n_i(wp_n),
    .quad_command_mode_i(qmode), .pe_req_i(pe_req), .pe_addr_i(pe_addr), .pe_refused_o(pe_refused),
    .status_o(st), .config_reg_o(cr), .hard_protect_mode_o(hard_protect_mode), .drive_ohms_o(ohms),
    .dummy_fast_o(dfast), .dummy_quad_io_o(dqio));
  fcw_host_model u_fcw_host_model (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
    .so_i(so), .so_oe_n_i(so_oe_n));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Length of the last busy period, in clock cycles.
  always @(negedge clk_i) begin
    if (st[0] === 1'b1) begin
      busy_run <= busy_run + 1;
    end else begin
      if (busy_run != 0) begin
        busy_len <= busy_run;
      end
      busy_run <= 0;
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (st[0] !== lvl && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (st[0] !== lvl) begin
      miscompares++;
      $display("ERROR t=%0t busy=%h exp=%h", $time, st[0], lvl);
      final_report();
    end
  endtask : wait_busy

  task automatic cmd(input logic [7:0] op);
    logic [15:0] r;
    u_fcw_host_model.xfer({op, 16'h0000}, 8, r);
  endtask : cmd

  task automatic write_status_cmd(input logic [7:0] s, input logic [7:0] c, input int n);
    logic [15:0] r;
    cmd(`FCW_OP_WRITE_ENABLE_CMD);
    u_fcw_host_model.xfer({`FCW_OP_WRITE_STATUS_CMD, s, c}, n, r);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 100);
    @(negedge clk_i);
  endtask : write_status_cmd

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    check(st, 8'h00);
    check(cr, 8'h07);
    check({1'b0, ohms}, 8'h1e);
    check({4'h0, dfast}, 8'h08);
    check({4'h0, dqio}, 8'h06);
    check({7'h00, hard_protect_mode}, 8'h00);
  endtask : t_reset

  task automatic t_no_latch();
    logic [15:0] r;
    u_fcw_host_model.xfer({`FCW_OP_WRITE_STATUS_CMD, 8'h3c, 8'h45}, 24, r);
    repeat (20) @(negedge clk_i);
    check(st, 8'h00);
    check(cr, 8'h07);
  endtask : t_no_latch

  task automatic t_write();
    logic [15:0] r;
    cmd(`FCW_OP_WRITE_ENABLE_CMD);
    check(st, 8'h02);
    u_fcw_host_model.xfer({`FCW_OP_WRITE_STATUS_CMD, 8'h0f, 8'h49}, 24, r);
    wait_busy(1'b1, 6);
    check(st, 8'h03);
    wait_busy(1'b0, 100);
    @(negedge clk_i);
    check(8'(busy_len), 8'(TW_CYC));
    check(st, 8'h0c);
    check(cr, 8'h49);
    check({1'b0, ohms}, 8'h5a);
    check({dfast, dqio}, 8'h64);
  endtask : t_write

  task automatic t_bad_count();
    logic [15:0] r;
    cmd(`FCW_OP_WRITE_ENABLE_CMD);
    u_fcw_host_model.xfer({`FCW_OP_WRITE_STATUS_CMD, 8'h3c, 8'h00}, 20, r);
    repeat (20) @(negedge clk_i);
    check({st[7:2], 2'b00}, 8'h0c);
    check(cr, 8'h49);
  endtask : t_bad_count

  task automatic t_codes();
    int i;
    logic [2:0] k;
    for (i = 0; i < 8; i++) begin
      k = 3'(i);
      write_status_cmd(8'h0c, {k[1:0], 3'b000, k}, 24);
      check(cr, {k[1:0], 3'b001, k});
      check({1'b0, ohms}, {1'b0, OHM[k]});
      check({dfast, dqio}, {DF[k[1:0]], DQ[k[1:0]]});
    end
  endtask : t_codes

  task automatic t_short_pe();
    write_status_cmd(8'h04, 8'h00, 16);
    check(st, 8'h04);
    check(cr, 8'hcf);
    pe_req = 1'b1;
    pe_addr = 25'h0000000;
    @(negedge clk_i);
    check({7'h00, pe_refused}, 8'h01);
    pe_addr = 25'h1ffffff;
    @(negedge clk_i);
    check({7'h00, pe_refused}, 8'h00);
    pe_req = 1'b0;
  endtask : t_short_pe

  task automatic t_wide_read();
    logic [15:0] r;
    cmd(`FCW_OP_EN_WIDE);
    check(cr, 8'hef);
    cmd(`FCW_OP_EX_WIDE);
    check(cr, 8'hcf);
    u_fcw_host_model.xfer({`FCW_OP_RDSR, 16'h0000}, 16, r);
    check(r[7:0], 8'h04);
    u_fcw_host_model.xfer({`FCW_OP_RDCR, 16'h0000}, 16, r);
    check(r[7:0], 8'hcf);
  endtask : t_wide_read

  task automatic t_protect();
    logic [15:0] r;
    wp_n = 1'b0;
    write_status_cmd(8'h84, 8'h00, 16);
    check(st, 8'h84);
    repeat (6) @(negedge clk_i);
    check({7'h00, hard_protect_mode}, 8'h01);
    cmd(`FCW_OP_WRITE_ENABLE_CMD);
    u_fcw_host_model.xfer({`FCW_OP_WRITE_STATUS_CMD, 8'h00, 8'h00}, 16, r);
    repeat (20) @(negedge clk_i);
    check({st[7:2], 2'b00}, 8'h84);
    qmode = 1'b1;
    repeat (6) @(negedge clk_i);
    check({7'h00, hard_protect_mode}, 8'h00);
    qmode = 1'b0;
    repeat (6) @(negedge clk_i);
    check({7'h00, hard_protect_mode}, 8'h01);
    wp_n = 1'b1;
    repeat (6) @(negedge clk_i);
    check({7'h00, hard_protect_mode}, 8'h00);
    write_status_cmd(8'h00, 8'h00, 16);
    check(st, 8'h00);
  endtask : t_protect

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    wp_n = 1'b1;
    qmode = 1'b0;
    pe_req = 1'b0;
    pe_addr = 25'h0000000;
    miscompares = 0;
    checked = 0;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_no_latch();
    t_write();
    t_bad_count();
    t_codes();
    t_short_pe();
    t_wide_read();
    t_protect();
    final_report();
  end
endmodule : tb_top
